// *** hdl/bic_top.sv ***
// Board interrupt conditioning: synchronises on-board sources, combines, routes,
// converts edges to levels, gates the NMI and drives the system-bus requests.
// Assumes a single 200 MHz aclk, synchronous active-low reset and an AXI4-Lite master.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Two combined outputs, each the OR of its assigned ones among six combining inputs.
// - A source used as a combining input is removed from the eight request outputs.
// - Halt-timeout control suppresses the failsafe bus timeout while the CPU halts.
// - Two request lines per expansion module site, four in total.
// - After reset timer 0 is routed to request line two; timer 1 unrouted.
// - Serial transmit-ready request follows the serial controller's ready level.
// - Serial receive-ready request follows the character-waiting level.
// - Power fail normally drives the non-maskable interrupt.
// - The active-low external input is inverted before routing.
// - Edge converter captures an edge and holds a level request.
// - Edge converter source and destination request input are both selectable.
// - With the mask path on, mask high passes NMI and low blocks it.
// - The NMI mask level is a status register bit.
// - Status register is written at every odd index from C8 to DF.
// - Second system-bus output is enabled by default, then needs a line chosen.
// - First system-bus output needs its own enable and a chosen line.
// - Both parallel-port lines can be routed to any request input.
// - The coprocessor source only counts when the coprocessor is fitted.
// - Status bit 2 drives the NMI mask line.
// - Status bit 4 drives bus output A; bit 5 drives bus output B and lamp.
module bic_top #(
  parameter int AW = 12
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Asynchronous interrupt source pins
  input  wire logic          timer_ch0_irq,
  input  wire logic          timer_ch1_irq,
  input  wire logic          serial_tx_ready_irq,
  input  wire logic          serial_rx_ready_irq,
  input  wire logic          par_port_a_irq,
  input  wire logic          par_port_b_irq,
  input  wire logic          module1_irq_0,
  input  wire logic          module1_irq_1,
  input  wire logic          module2_irq_0,
  input  wire logic          module2_irq_1,
  input  wire logic          line_freq_tick,
  input  wire logic          math_coproc_irq,
  input  wire logic          power_fail_irq_n,
  input  wire logic          external_irq0_n,
  input  wire logic          failsafe_timeout_in,
  input  wire logic          halt_timeout_disable_n,
  // Acknowledge from the interrupt controller, same clock
  input  wire logic          edge_capture_ack,
  // Outputs to controller, CPU and system bus
  output logic [7:0]         ctrl_request_in,
  output logic               combined_irq_out_a,
  output logic               combined_irq_out_b,
  output logic               cpu_nmi_out,
  output logic               failsafe_timeout_out,
  output logic               edge_capture_level_out,
  output logic               sysbus_irq_out_a,
  output logic               sysbus_irq_out_b,
  output logic [7:0]         sysbus_irq_lines,
  output logic               status_lamp_out
);

  localparam int NS = bic_pkg::NSRC;

  typedef struct packed {
    // Software registers
    logic [7:0]                  status;
    logic [7:0][NS-1:0]          route;
    logic [29:0]                 comb_src;
    logic [11:0]                 comb_assign;
    logic [7:0]                  edge_cfg;
    logic [5:0]                  options;
    logic [7:0]                  busline;
    logic                        edge_clear;
    // Bus slave
    logic                        aw_got;
    logic                        w_got;
    logic [7:0]                  aw_idx;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    // Registered outputs
    logic [7:0]                  req;
    logic                        comb_a;
    logic                        comb_b;
    logic                        nmi;
    logic                        failsafe;
    logic                        edge_out;
    logic                        bus_a;
    logic                        bus_b;
    logic [7:0]                  bus_lines;
    logic                        lamp;
  } bic_state_t;

  bic_state_t                  r;
  bic_state_t                  n;
  logic [bic_pkg::NPIN-1:0]    pins;
  logic [bic_pkg::NPIN-1:0]    pins_sync;
  logic [NS-1:0]               src;
  logic [NS-1:0]               used;
  logic [bic_pkg::NCOMB-1:0]   comb_in;
  logic                        edge_sample;
  logic                        edge_level;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin bundle; every pin crosses two flops before use
  assign pins = {halt_timeout_disable_n, failsafe_timeout_in, external_irq0_n,
                 power_fail_irq_n, math_coproc_irq, line_freq_tick,
                 module2_irq_1, module2_irq_0, module1_irq_1, module1_irq_0,
                 par_port_b_irq, par_port_a_irq, serial_rx_ready_irq,
                 serial_tx_ready_irq, timer_ch1_irq, timer_ch0_irq};

  bic_sync #(
    .W (bic_pkg::NPIN)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (pins),
    .level_out (pins_sync)
  );

  // Active-high source vector; lows are inverted, coprocessor gated by fit
  always_comb begin
    src                          = pins_sync[NS-1:0];
    src[bic_pkg::SRC_POWER_FAIL] = !pins_sync[bic_pkg::SRC_POWER_FAIL];
    src[bic_pkg::SRC_EXTERNAL]   = !pins_sync[bic_pkg::SRC_EXTERNAL];
    src[bic_pkg::SRC_MATH]       = pins_sync[bic_pkg::SRC_MATH] &&
                                   r.options[bic_pkg::OPT_COPROC];
  end

  // Edge converter source select; out-of-range selects read as idle
  always_comb begin
    edge_sample = 1'b0;
    if (r.edge_cfg[3:0] < 4'(NS)) begin
      edge_sample = src[r.edge_cfg[3:0]];
    end
  end

  bic_edge_hold u_edge (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (r.edge_cfg[bic_pkg::EDGE_EN]),
    .sample_in (edge_sample),
    .ack       (edge_capture_ack),
    .clear     (r.edge_clear),
    .level_out (edge_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Odd indices from C8 to DF all alias the status register
  function automatic logic is_status(input logic [7:0] idx);
    return idx >= bic_pkg::IDX_STATUS_LO && idx <= bic_pkg::IDX_STATUS_HI && idx[0];
  endfunction

  // Read view of every register; unmapped indices give zero
  function automatic logic [32:0] read_reg(input bic_state_t s, input logic [7:0] idx,
                                           input logic [NS-1:0] srcv, input logic lvl);
    logic [32:0] res;
    res = {1'b0, 32'h0000_0000};
    if (is_status(idx)) begin
      res = {1'b1, 24'h00_0000, s.status};
    end else if (idx < bic_pkg::IDX_COMB_SRC) begin
      res = {1'b1, 17'h0_0000, s.route[idx[2:0]]};
    end else begin
      case (idx)
        bic_pkg::IDX_COMB_SRC:    res = {1'b1, 2'b00, s.comb_src};
        bic_pkg::IDX_COMB_ASSIGN: res = {1'b1, 20'h0_0000, s.comb_assign};
        bic_pkg::IDX_EDGE_CFG:    res = {1'b1, 24'h00_0000, s.edge_cfg};
        bic_pkg::IDX_OPTIONS:     res = {1'b1, 26'h000_0000, s.options};
        bic_pkg::IDX_BUSLINE:     res = {1'b1, 24'h00_0000, s.busline};
        bic_pkg::IDX_SRC_STATE:   res = {1'b1, 16'h0000, lvl, srcv};
        default:                  res = {1'b0, 32'h0000_0000};
      endcase
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, registers and all routed outputs
  always_comb begin
    logic [32:0] rd;
    logic [31:0] wv;
    logic [3:0]  sel;
    logic        do_write;
    rd       = {1'b0, 32'h0000_0000};
    wv       = 32'h0000_0000;
    sel      = 4'h0;
    do_write = 1'b0;
    n        = r;
    n.edge_clear = 1'b0;

    // Address and data are taken in either order, then answered together
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      do_write = 1'b1;
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = bic_pkg::RESP_SLVERR;
    end

    // Register writes; read-only and unmapped indices answer with an error
    if (do_write) begin
      rd = read_reg(r, r.aw_idx, src, edge_level);
      wv = merge(rd[31:0], r.wdata, r.wstrb);
      if (is_status(r.aw_idx)) begin
        n.status = wv[7:0];
        n.bresp  = bic_pkg::RESP_OKAY;
      end else if (r.aw_idx < bic_pkg::IDX_COMB_SRC) begin
        n.route[r.aw_idx[2:0]] = wv[NS-1:0];
        n.bresp                = bic_pkg::RESP_OKAY;
      end else if (r.aw_idx != bic_pkg::IDX_SRC_STATE && rd[32]) begin
        n.bresp = bic_pkg::RESP_OKAY;
        case (r.aw_idx)
          bic_pkg::IDX_COMB_SRC:    n.comb_src    = wv[29:0];
          bic_pkg::IDX_COMB_ASSIGN: n.comb_assign = wv[11:0];
          bic_pkg::IDX_EDGE_CFG: begin
            n.edge_cfg   = wv[7:0];
            n.edge_clear = wv[bic_pkg::EDGE_CLEAR];
          end
          bic_pkg::IDX_OPTIONS:     n.options     = wv[5:0];
          bic_pkg::IDX_BUSLINE:     n.busline     = wv[7:0];
          default:                  n.bresp       = bic_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Read channel: one outstanding read, answered the cycle after the address
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      rd       = read_reg(r, s_axi_araddr[9:2], src, edge_level);
      n.rvalid = 1'b1;
      n.rdata  = rd[31:0];
      n.rresp  = rd[32] ? bic_pkg::RESP_OKAY : bic_pkg::RESP_SLVERR;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;

    // Combining inputs, each a selected source, ORed onto two outputs
    used    = '0;
    comb_in = '0;
    for (int i = 0; i < bic_pkg::NCOMB; i++) begin
      sel = r.comb_src[i*bic_pkg::COMB_FIELD +: 4];
      if (r.comb_src[i*bic_pkg::COMB_FIELD + 4] && sel < 4'(NS)) begin
        comb_in[i] = src[sel];
        used[sel]  = 1'b1;
      end
    end
    n.comb_a = |(comb_in & r.comb_assign[5:0]);
    n.comb_b = |(comb_in & r.comb_assign[11:6]);

    // Request routing; combined sources are held off the controller inputs
    for (int k = 0; k < bic_pkg::NREQ; k++) begin
      n.req[k] = |(src & r.route[k] & ~used) ||
                 (edge_level && r.edge_cfg[7:5] == 3'(k));
    end
    n.edge_out = edge_level;

    // NMI gate: mask line passes when high, blocks when low
    n.nmi = src[bic_pkg::SRC_POWER_FAIL] && r.options[bic_pkg::OPT_PF_TO_NMI] &&
            (!r.options[bic_pkg::OPT_MASK_PATH] || r.status[bic_pkg::ST_NMI_MASK]);

    // Halt-timeout control, active low, only while its control is enabled
    n.failsafe = src[bic_pkg::SRC_FAILSAFE] &&
                 !(r.options[bic_pkg::OPT_HALT_CTL] &&
                   !pins_sync[bic_pkg::PIN_HALT_N]);

    // System-bus requests from status bits, each to one chosen line
    n.bus_a = r.status[bic_pkg::ST_BUS_OUT_A] && r.options[bic_pkg::OPT_BUS_A_EN];
    n.bus_b = r.status[bic_pkg::ST_BUS_OUT_B] && r.options[bic_pkg::OPT_BUS_B_EN];
    n.lamp  = r.status[bic_pkg::ST_BUS_OUT_B];
    for (int j = 0; j < 8; j++) begin
      n.bus_lines[j] = (n.bus_a && r.busline[bic_pkg::BUSLINE_A_VALID] &&
                        r.busline[2:0] == 3'(j)) ||
                       (n.bus_b && r.busline[bic_pkg::BUSLINE_B_VALID] &&
                        r.busline[6:4] == 3'(j));
    end

    // Synchronous reset to documented defaults
    if (!aresetn) begin
      n         = '0;
      n.status  = bic_pkg::STATUS_RST;
      n.options = bic_pkg::OPTIONS_RST;
      n.route[bic_pkg::ROUTE_TIMER0_RQ] = bic_pkg::ROUTE_TIMER0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign s_axi_awready          = r.awready;
  assign s_axi_wready           = r.wready;
  assign s_axi_bvalid           = r.bvalid;
  assign s_axi_bresp            = r.bresp;
  assign s_axi_arready          = r.arready;
  assign s_axi_rvalid           = r.rvalid;
  assign s_axi_rdata            = r.rdata;
  assign s_axi_rresp            = r.rresp;
  assign ctrl_request_in        = r.req;
  assign combined_irq_out_a     = r.comb_a;
  assign combined_irq_out_b     = r.comb_b;
  assign cpu_nmi_out            = r.nmi;
  assign failsafe_timeout_out   = r.failsafe;
  assign edge_capture_level_out = r.edge_out;
  assign sysbus_irq_out_a       = r.bus_a;
  assign sysbus_irq_out_b       = r.bus_b;
  assign sysbus_irq_lines       = r.bus_lines;
  assign status_lamp_out        = r.lamp;

endmodule : bic_top

// *** hdl/bic_pkg.sv ***
// Constants shared by the board interrupt conditioning block.
// Assumes a 32-bit AXI4-Lite register bus; byte address is four times the register index.
package bic_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt source positions after synchronising and inversion
  localparam int NSRC            = 15;
  localparam int SRC_TIMER0      = 0;
  localparam int SRC_TIMER1      = 1;
  localparam int SRC_SER_TX      = 2;
  localparam int SRC_SER_RX      = 3;
  localparam int SRC_PAR_A       = 4;
  localparam int SRC_PAR_B       = 5;
  localparam int SRC_MOD1_0      = 6;
  localparam int SRC_MOD1_1      = 7;
  localparam int SRC_MOD2_0      = 8;
  localparam int SRC_MOD2_1      = 9;
  localparam int SRC_LINE_TICK   = 10;
  localparam int SRC_MATH        = 11;
  localparam int SRC_POWER_FAIL  = 12;
  localparam int SRC_EXTERNAL    = 13;
  localparam int SRC_FAILSAFE    = 14;
  // Raw pin bundle: the sources plus the halt-timeout control at the top
  localparam int NPIN            = 16;
  localparam int PIN_HALT_N      = 15;

  localparam int NREQ            = 8;
  localparam int NCOMB           = 6;
  localparam int COMB_FIELD      = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [7:0] IDX_ROUTE_BASE  = 8'h00;
  localparam logic [7:0] IDX_COMB_SRC    = 8'h08;
  localparam logic [7:0] IDX_COMB_ASSIGN = 8'h09;
  localparam logic [7:0] IDX_EDGE_CFG    = 8'h0A;
  localparam logic [7:0] IDX_OPTIONS     = 8'h0B;
  localparam logic [7:0] IDX_BUSLINE     = 8'h0C;
  localparam logic [7:0] IDX_SRC_STATE   = 8'h0D;
  localparam logic [7:0] IDX_STATUS_LO   = 8'hC8;
  localparam logic [7:0] IDX_STATUS_HI   = 8'hDF;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ST_NMI_MASK     = 2;
  localparam int ST_BUS_OUT_A    = 4;
  localparam int ST_BUS_OUT_B    = 5;
  localparam int OPT_MASK_PATH   = 0;
  localparam int OPT_PF_TO_NMI   = 1;
  localparam int OPT_BUS_A_EN    = 2;
  localparam int OPT_BUS_B_EN    = 3;
  localparam int OPT_COPROC      = 4;
  localparam int OPT_HALT_CTL    = 5;
  localparam int EDGE_EN         = 4;
  localparam int EDGE_DEST_LSB   = 5;
  localparam int EDGE_CLEAR      = 8;
  localparam int BUSLINE_A_VALID = 3;
  localparam int BUSLINE_B_LSB   = 4;
  localparam int BUSLINE_B_VALID = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]      STATUS_RST      = 8'h00;
  localparam logic [5:0]      OPTIONS_RST     = 6'h0B;
  localparam int              ROUTE_TIMER0_RQ = 2;
  localparam logic [NSRC-1:0] ROUTE_TIMER0    = 15'h0001;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : bic_pkg

// *** hdl/bic_sync.sv ***
// Two-flip-flop synchroniser bank for the asynchronous interrupt pins.
// Assumes each bit is an independent level; no multi-bit coherence is implied.
module bic_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } bic_sync_state_t;

  bic_sync_state_t r;
  bic_sync_state_t n;

  ////////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    n = r;
    for (int i = 0; i < W; i++) begin
      n.stage1[i] = pin_in[i];
      n.stage2[i] = r.stage1[i];
    end
    if (!aresetn) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign level_out = r.stage2;

endmodule : bic_sync

// *** hdl/bic_edge_hold.sv ***
// Edge-to-level converter: a rising edge on the selected source becomes a held request.
// Assumes sample_in is already synchronous to aclk and active high.
module bic_edge_hold (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic enable,
  input  wire logic sample_in,
  input  wire logic ack,
  input  wire logic clear,
  // Held request
  output logic      level_out
);

  typedef struct packed {
    logic last;
    logic held;
  } bic_edge_state_t;

  bic_edge_state_t r;
  bic_edge_state_t n;
  logic            rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Capture wins over an acknowledge in the same cycle so no edge is lost
  always_comb begin
    n      = r;
    rise   = enable && sample_in && !r.last;
    n.last = sample_in;
    if (rise) begin
      n.held = 1'b1;
    end else if (ack || clear || !enable) begin
      n.held = 1'b0;
    end
    if (!aresetn) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign level_out = r.held;

endmodule : bic_edge_hold

// *** sim/bic_props.sv ***
// Checker for the board interrupt block, watching top-level ports only.
// Assumes a bind onto bic_top; one clock, synchronous active-low reset.
module bic_props (
  // Clock, reset and inputs watched
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       power_fail_irq_n,
  input wire logic       failsafe_timeout_in,
  input wire logic       edge_capture_ack,
  input wire logic       s_axi_bready,
  // Outputs watched
  input wire logic       s_axi_bvalid,
  input wire logic       cpu_nmi_out,
  input wire logic       failsafe_timeout_out,
  input wire logic       edge_capture_level_out,
  input wire logic       sysbus_irq_out_a,
  input wire logic       sysbus_irq_out_b,
  input wire logic [7:0] sysbus_irq_lines,
  input wire logic       status_lamp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin-to-output latency is three edges, so causes are looked up three back
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_CLEAR: assert property ($rose(aresetn) |-> !sysbus_irq_out_a && !status_lamp_out)
    else $error("bus request or lamp set right after reset");
  AST_RST_NMI: assert property ($rose(aresetn) |-> !cpu_nmi_out && sysbus_irq_lines == 8'h00)
    else $error("nmi or bus lines set right after reset");
  AST_LAMP_B: assert property (sysbus_irq_out_b |-> status_lamp_out)
    else $error("bus output b without lamp");
  AST_NMI_CAUSE: assert property (cpu_nmi_out |-> !$past(power_fail_irq_n, 3))
    else $error("nmi without power fail");
  AST_FSAFE: assert property (failsafe_timeout_out |-> $past(failsafe_timeout_in, 3))
    else $error("failsafe out without its input");
  AST_LINES: assert property (|sysbus_irq_lines |-> sysbus_irq_out_a || sysbus_irq_out_b)
    else $error("bus line driven with both bus outputs off");
  AST_ACK_CLEARS: assert property (edge_capture_ack [*3] |-> !edge_capture_level_out)
    else $error("held edge request survives acknowledge");
  AST_BRESP_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // Main scenarios reached
  cover property ($rose(cpu_nmi_out));
  cover property ($rose(edge_capture_level_out));
  cover property (|sysbus_irq_lines);
endmodule // bic_props

// *** sim/bic_pic_model.sv ***
// Controller-side model: acknowledges the held edge request.
// Assumes the block's clock; delay sets a prompt or slow answer.
module bic_pic_model (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Request in, acknowledge out
  input wire logic       level_in,
  input wire logic [3:0] delay,
  output logic           ack = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  // Ack stays up until the request drops, so a late clear is still seen
  always @(posedge aclk) begin
    wait_cnt <= (aresetn && level_in) ? wait_cnt + 1 : 0;
    ack      <= aresetn && level_in && wait_cnt >= delay;
  end
endmodule // bic_pic_model

// *** sim/test_bic_top.sv ***
// Self-checking bench for the interrupt block with a controller model.
// Assumes bic_top ports, a 200 MHz clock and the block's register map.
module test_bic_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, ack_delay = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        timer_ch0_irq = 0, timer_ch1_irq = 0, serial_tx_ready_irq = 0;
  logic        serial_rx_ready_irq = 0, par_port_a_irq = 0, par_port_b_irq = 0;
  logic        module1_irq_0 = 0, module1_irq_1 = 0, module2_irq_0 = 0, module2_irq_1 = 0;
  logic        line_freq_tick = 0, math_coproc_irq = 0, power_fail_irq_n = 1;
  logic        external_irq0_n = 1, failsafe_timeout_in = 0, halt_timeout_disable_n = 1;
  logic        edge_capture_ack, combined_irq_out_a, combined_irq_out_b, cpu_nmi_out;
  logic        failsafe_timeout_out, edge_capture_level_out, sysbus_irq_out_a;
  logic        sysbus_irq_out_b, status_lamp_out;
  logic [7:0]  ctrl_request_in, sysbus_irq_lines;
  logic [14:0] v;
  int          errors = 0, checks_done = 0, st_m, opt_m = 32'h0000_000B, j;
  bic_top uut (.*);
  bic_pic_model u_pic (.aclk(aclk), .aresetn(aresetn), .level_in(edge_capture_level_out),
                       .delay(ack_delay), .ack(edge_capture_ack));
  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus cycles: payload held until each channel's own ready
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    tick(1);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] i);
    tick(1);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  // Pins settle three edges after a change; five leaves margin
  task automatic pins(input logic [14:0] p);
    {failsafe_timeout_in, external_irq0_n, power_fail_irq_n, math_coproc_irq, line_freq_tick,
     module2_irq_1, module2_irq_0, module1_irq_1, module1_irq_0, par_port_b_irq,
     par_port_a_irq, serial_rx_ready_irq, serial_tx_ready_irq, timer_ch1_irq,
     timer_ch0_irq} <= p;
    tick(5);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'haec2_262a));
    tick(10);
    aresetn <= 1'h1;
    tick(4);
    for (int r = 0; r < 2; r++) begin
      rdr(8'hC9);
      chk(rd, 32'h0000_0000);
      rdr(8'h0B);
      chk(rd, 32'h0000_000B);
      rdr(8'h02);
      chk(rd, 32'h0000_0001);
      chk(sysbus_irq_out_b, 1'h0);
      repeat (4) begin
        v = 15'($urandom);
        pins(v);
        rdr(8'h0D);
        chk(rd, {17'h0, (v ^ 15'h3000) & 15'h77FF});
        chk(ctrl_request_in, {5'h0, v[0], 2'h0});
      end
      pins(15'h3000);
      for (int k = 0; k < 4; k++) begin
        st_m = $urandom & 32'h0000_00FF;
        wr(8'hC9 + 8'(2 * ($urandom % 12)), st_m);
        rdr(8'hDF);
        chk(rd, st_m);
        chk(status_lamp_out, st_m[5]);
        chk(sysbus_irq_out_b, st_m[5]);
        chk(sysbus_irq_out_a, opt_m[2] & st_m[4]);
        opt_m = k[0] ? 32'h0000_000F : 32'h0000_000B;
        wr(8'h0B, opt_m);
      end
      j = $urandom % 8;
      wr(8'hC9, 32'h0000_0030);
      wr(8'h0C, 32'h0000_0088 | (j << 4) | (7 - j));
      wr(8'hC8, 32'h0000_00FF);
      chk(sysbus_irq_lines, (1 << j) | (1 << (7 - j)));
      chk(rs, 2'h2);
      pins(15'h2000);
      chk(cpu_nmi_out, 1'h0);
      wr(8'hC9, 32'h0000_0034);
      tick(2);
      chk(cpu_nmi_out, 1'h1);
      halt_timeout_disable_n <= 1'h0;
      wr(8'h0B, 32'h0000_003F);
      pins(15'h7000);
      chk(failsafe_timeout_out, 1'h0);
      halt_timeout_disable_n <= 1'h1;
      pins(15'h7000);
      chk(failsafe_timeout_out, 1'h1);
      wr(8'h08, 32'h0000_0014);
      wr(8'h09, 32'h0000_0041);
      wr(8'h05, 32'h0000_0810);
      wr(8'h03, 32'h0000_0020);
      pins(15'h3830);
      chk({combined_irq_out_a, combined_irq_out_b, ctrl_request_in}, 10'h328);
      wr(8'h0A, 32'h0000_003D);
      for (int d = 0; d < 2; d++) begin
        ack_delay <= d ? 4'h1 : 4'hF;
        pins(15'h1000);
        pins(15'h3000);
        chk(ctrl_request_in, d ? 8'h00 : 8'h02);
        tick(20);
        chk(edge_capture_level_out, 1'h0);
      end
      aresetn <= 1'h0;
      tick(2);
      aresetn <= 1'h1;
      opt_m = 32'h0000_000B;
      tick(4);
    end
    tally_and_finish();
  end
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    tick(20000);
    errors++;
    tally_and_finish();
  end
endmodule // test_bic_top
bind bic_top bic_props u_props (.*);
